/* pkg/fsbc_map.vh */
// fsbc_map.vh: offsets, status fields, command codes and reset values
// of the flash status and blank-check block; included by every core file.
`ifndef FSBC_MAP_VH
`define FSBC_MAP_VH

// register word offsets on the axi4-lite slave (byte addresses)
`define FSBC_REG_STATUS     8'h00
`define FSBC_REG_LOCK       8'h04
`define FSBC_REG_INFO       8'h08

// status word bit positions
`define FSBC_ST_READY       7
`define FSBC_ST_ESUSP       6
`define FSBC_ST_ERASE_ERR   5
`define FSBC_ST_PROG_ERR    4
`define FSBC_ST_RSVD        3
`define FSBC_ST_PSUSP       2
`define FSBC_ST_LOCK_ERR    1
`define FSBC_ST_BANK        0
`define FSBC_ST_RESET       8'h80

// lock register fields
`define FSBC_LOCK_EN        31
`define FSBC_LOCK_SECURE    30
`define FSBC_LOCK_RESET     32'h0000_0000
`define FSBC_SECURE_SECTOR  14'h0000

// command address and command codes (low data byte)
`define FSBC_CMD_OFFSET     12'h555
`define FSBC_CMD_BLANK      8'h33
`define FSBC_CMD_PROG       8'h10
`define FSBC_CMD_ERASE      8'h20
`define FSBC_CMD_PSUSP      8'h51
`define FSBC_CMD_PRESUME    8'h52
`define FSBC_CMD_ESUSP      8'h61
`define FSBC_CMD_ERESUME    8'h62
`define FSBC_CMD_CLR_STATUS 8'h71
`define FSBC_CMD_STATUS_RD  8'h70
`define FSBC_CMD_DATA_HI    8'h00

// array and sector geometry
`define FSBC_ERASED_WORD    16'hffff
`define FSBC_SECT_LSB       12
`define FSBC_SECT_WORDS     4096

// axi response codes
`define FSBC_RESP_OKAY      2'b00
`define FSBC_RESP_DECERR    2'b11

`endif

/* core/fsbc_wr_capture.v */
// fsbc_wr_capture: turns the asynchronous write strobes into one command pulse.
// assumes all flash pins are already synchronous to aclk.
`timescale 1ns/1ps
`include "fsbc_map.vh"

module fsbc_wr_capture #(
    parameter ADDR_W = 26
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              ce_n,
    input  wire              oe_n,
    input  wire              we_n,
    input  wire              address_valid_n,
    input  wire [ADDR_W-1:0] addr,
    input  wire [15:0]       dq,
    output wire              cmd_stb,
    output wire [ADDR_W-1:0] cmd_addr,
    output wire [15:0]       cmd_data
);
    reg              astb_d_r;
    reg              we_d_r;
    reg              fresh_r;
    reg [ADDR_W-1:0] addr_r;
    reg [15:0]       data_r;
    reg              stb_r;

    wire write_phase = !ce_n && oe_n;
    wire astb_rise   = !astb_d_r && address_valid_n;
    wire we_rise     = !we_d_r && we_n;

    always @(posedge aclk) begin
        if (!aresetn) begin
            astb_d_r <= 1'b1;
            we_d_r  <= 1'b1;
            fresh_r <= 1'b0;
            addr_r  <= {ADDR_W{1'b0}};
            data_r  <= 16'h0000;
            stb_r   <= 1'b0;
        end else begin
            astb_d_r <= address_valid_n;
            we_d_r  <= we_n;
            stb_r   <= 1'b0;
            if (astb_rise && write_phase) begin
                addr_r  <= addr;
                fresh_r <= 1'b1;
            end
            // a second strobe without a new address is a burst beat: dropped
            if (we_rise && write_phase && fresh_r && !astb_rise) begin
                data_r  <= dq;
                stb_r   <= 1'b1;
                fresh_r <= 1'b0;
            end
        end
    end

    assign cmd_stb  = stb_r;
    assign cmd_addr = addr_r;
    assign cmd_data = data_r;
endmodule // fsbc_wr_capture

/* core/fsbc_blank_scan.v */
// fsbc_blank_scan: walks one sector word by word looking for a programmed bit.
// assumes the array answers scan_data one cycle after scan_rd.
`timescale 1ns/1ps
`include "fsbc_map.vh"

module fsbc_blank_scan #(
    parameter ADDR_W = 26,
    parameter SECT_W = 14,
    parameter WORDS  = `FSBC_SECT_WORDS
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              start,
    input  wire [SECT_W-1:0] sector,
    output wire [ADDR_W-1:0] scan_addr,
    output wire              scan_rd,
    input  wire [15:0]       scan_data,
    output wire              done,
    output wire              not_blank
);
    localparam S_IDLE = 2'd0;
    localparam S_RD   = 2'd1;
    localparam S_CHK  = 2'd2;
    localparam OFF_W  = ADDR_W - SECT_W;

    reg [1:0]        state_r;
    reg [OFF_W-1:0]  idx_r;
    reg [SECT_W-1:0] sect_r;
    reg              rd_r;
    reg              done_r;
    reg              not_blank_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= S_IDLE;
            idx_r       <= {OFF_W{1'b0}};
            sect_r      <= {SECT_W{1'b0}};
            rd_r        <= 1'b0;
            done_r      <= 1'b0;
            not_blank_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            rd_r   <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        sect_r  <= sector;
                        idx_r   <= {OFF_W{1'b0}};
                        rd_r    <= 1'b1;
                        state_r <= S_RD;
                    end
                end
                S_RD: begin
                    state_r <= S_CHK;
                end
                S_CHK: begin
                    if (scan_data != `FSBC_ERASED_WORD) begin
                        // first dirty word ends the scan at once
                        done_r      <= 1'b1;
                        not_blank_r <= 1'b1;
                        state_r     <= S_IDLE;
                    end else if (idx_r == WORDS[OFF_W-1:0] - 1'b1) begin
                        done_r      <= 1'b1;
                        not_blank_r <= 1'b0;
                        state_r     <= S_IDLE;
                    end else begin
                        idx_r   <= idx_r + 1'b1;
                        rd_r    <= 1'b1;
                        state_r <= S_RD;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    assign scan_addr = {sect_r, idx_r};
    assign scan_rd   = rd_r;
    assign done      = done_r;
    assign not_blank = not_blank_r;
endmodule // fsbc_blank_scan

/* core/fsbc_top.v */
// fsbc_top: command front end, embedded-operation sequencer, blank check and
// low status bits of a banked nor flash, with an axi4-lite status port.
// assumes flash pins synchronous to aclk; an external array engine runs
// program and erase and reports op_done with op_fail.
//
// How it works
// - bit 2 high while program suspended
// - bit 1 flags locked or secure-sector failure
// - lock error covers latest op; clear command
// - bits 6..1 meaningful only when ready
// - bit 0: addressed bank idle while busy
// - bit 3 reserved, reads zero
// - reads allowed in banks not busy
// - back-to-back read and write, no latency; rd_allow is registered, one cycle late
// - blank check: sector plus 555h, 0033h
// - array reads blocked during blank check
// - bit 5 set when sector not blank
// - blank check shows busy like erase
// - stop at first dirty word, go idle
// - address on valid rise, data on strobe
// - writes ignore the burst clock
// - one address and data per write
// - decode command from address and data
// - sector from top bit down to A12
// - ready high only with nothing running
// - program or erase busy: only suspend and status read taken; blank check takes none; code never decodes status read 70h
`timescale 1ns/1ps
`include "fsbc_map.vh"

module fsbc_top #(
    parameter ADDR_W = 26,
    parameter BANK_W = 4,
    parameter WORDS  = `FSBC_SECT_WORDS
) (
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite slave
    input  wire [7:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [7:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready,
    // flash write pins
    input  wire              flash_ce_n,
    input  wire              flash_oe_n,
    input  wire              flash_we_n,
    input  wire              address_valid_n,
    input  wire [ADDR_W-1:0] flash_addr,
    input  wire [15:0]       flash_dq_in,
    // array read arbitration
    input  wire              rd_req,
    input  wire [ADDR_W-1:0] rd_addr,
    output wire              rd_allow,
    // blank-check array port
    output wire [ADDR_W-1:0] scan_addr,
    output wire              scan_rd,
    input  wire [15:0]       scan_data,
    // embedded operation engine
    output wire              op_start,
    output wire              op_is_erase,
    output wire              op_hold,
    output wire [ADDR_W-13:0] op_sector,
    input  wire              op_done,
    input  wire              op_fail,
    output wire [7:0]        device_status_word
);
    localparam SECT_W   = ADDR_W - `FSBC_SECT_LSB;
    localparam ST_IDLE  = 3'd0;
    localparam ST_PROG  = 3'd1;
    localparam ST_ERASE = 3'd2;
    localparam ST_BLANK = 3'd3;
    localparam ST_PSUSP = 3'd4;
    localparam ST_ESUSP = 3'd5;

    // write front end; the burst clock has no port at all
    wire              cmd_stb;
    wire [ADDR_W-1:0] cmd_addr;
    wire [15:0]       cmd_data;

    fsbc_wr_capture #(.ADDR_W(ADDR_W)) u_cap (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .ce_n            (flash_ce_n),
        .oe_n            (flash_oe_n),
        .we_n            (flash_we_n),
        .address_valid_n (address_valid_n),
        .addr            (flash_addr),
        .dq              (flash_dq_in),
        .cmd_stb         (cmd_stb),
        .cmd_addr        (cmd_addr),
        .cmd_data        (cmd_data)
    );

    reg               scan_start_r;
    reg  [SECT_W-1:0] op_sector_r;
    wire              scan_done;
    wire              scan_not_blank;

    fsbc_blank_scan #(.ADDR_W(ADDR_W), .SECT_W(SECT_W), .WORDS(WORDS)) u_scan (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (scan_start_r),
        .sector    (op_sector_r),
        .scan_addr (scan_addr),
        .scan_rd   (scan_rd),
        .scan_data (scan_data),
        .done      (scan_done),
        .not_blank (scan_not_blank)
    );

    // command decode
    wire [SECT_W-1:0] cmd_sector = cmd_addr[ADDR_W-1:`FSBC_SECT_LSB];
    wire              cmd_at_cap = cmd_addr[`FSBC_SECT_LSB-1:0] == `FSBC_CMD_OFFSET;
    wire              cmd_ok     = cmd_stb && cmd_at_cap
                                   && cmd_data[15:8] == `FSBC_CMD_DATA_HI;
    wire [7:0]        code       = cmd_data[7:0];

    reg [2:0]  state_r;
    reg        op_start_r;
    reg        op_is_erase_r;
    reg        op_hold_r;
    reg        erase_err_r;
    reg        prog_err_r;
    reg        lock_err_r;
    reg [31:0] lock_cfg_r;
    reg        rd_allow_r;
    reg [7:0]  status_r;

    wire cmd_locked = (lock_cfg_r[`FSBC_LOCK_EN]
                       && cmd_sector == lock_cfg_r[SECT_W-1:0])
                      || (lock_cfg_r[`FSBC_LOCK_SECURE]
                       && cmd_sector == `FSBC_SECURE_SECTOR);

    wire busy = state_r == ST_PROG || state_r == ST_ERASE
                || state_r == ST_BLANK;

    always @(posedge aclk) begin
        if (!aresetn) begin
            // reset abandons any running operation
            state_r       <= ST_IDLE;
            op_start_r    <= 1'b0;
            op_is_erase_r <= 1'b0;
            op_hold_r     <= 1'b0;
            op_sector_r   <= {SECT_W{1'b0}};
            scan_start_r  <= 1'b0;
            erase_err_r   <= 1'b0;
            prog_err_r    <= 1'b0;
            lock_err_r    <= 1'b0;
        end else begin
            op_start_r   <= 1'b0;
            scan_start_r <= 1'b0;
            // unmatched codes fall through every branch untouched
            case (state_r)
                ST_IDLE: begin
                    if (cmd_ok && (code == `FSBC_CMD_PROG || code == `FSBC_CMD_ERASE)) begin
                        if (cmd_locked) begin
                            lock_err_r <= 1'b1;
                        end else begin
                            lock_err_r    <= 1'b0;
                            op_sector_r   <= cmd_sector;
                            op_is_erase_r <= code == `FSBC_CMD_ERASE;
                            op_start_r    <= 1'b1;
                            state_r       <= (code == `FSBC_CMD_ERASE) ? ST_ERASE : ST_PROG;
                        end
                    end else if (cmd_ok && code == `FSBC_CMD_BLANK) begin
                        op_sector_r  <= cmd_sector;
                        scan_start_r <= 1'b1;
                        state_r      <= ST_BLANK;
                    end else if (cmd_ok && code == `FSBC_CMD_CLR_STATUS) begin
                        erase_err_r <= 1'b0;
                        prog_err_r  <= 1'b0;
                        lock_err_r  <= 1'b0;
                    end
                end
                ST_PROG: begin
                    if (op_done) begin
                        prog_err_r <= op_fail;
                        state_r    <= ST_IDLE;
                    end else if (cmd_ok && code == `FSBC_CMD_PSUSP) begin
                        op_hold_r <= 1'b1;
                        state_r   <= ST_PSUSP;
                    end
                end
                ST_ERASE: begin
                    if (op_done) begin
                        erase_err_r <= op_fail;
                        state_r     <= ST_IDLE;
                    end else if (cmd_ok && code == `FSBC_CMD_ESUSP) begin
                        op_hold_r <= 1'b1;
                        state_r   <= ST_ESUSP;
                    end
                end
                ST_BLANK: begin
                    // every write is ignored until the scan reports
                    if (scan_done) begin
                        erase_err_r <= scan_not_blank;
                        state_r     <= ST_IDLE;
                    end
                end
                ST_PSUSP: begin
                    if (cmd_ok && code == `FSBC_CMD_PRESUME) begin
                        op_hold_r <= 1'b0;
                        state_r   <= ST_PROG;
                    end
                end
                ST_ESUSP: begin
                    if (cmd_ok && code == `FSBC_CMD_ERESUME) begin
                        op_hold_r <= 1'b0;
                        state_r   <= ST_ERASE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // status word and read arbitration
    wire [BANK_W-1:0] op_bank   = op_sector_r[SECT_W-1 -: BANK_W];
    wire [BANK_W-1:0] addr_bank = cmd_addr[ADDR_W-1 -: BANK_W];
    wire [BANK_W-1:0] rd_bank   = rd_addr[ADDR_W-1 -: BANK_W];
    reg  [7:0]        status_nxt;

    always @* begin
        status_nxt                     = 8'h00;
        status_nxt[`FSBC_ST_READY]     = !busy;
        status_nxt[`FSBC_ST_ESUSP]     = state_r == ST_ESUSP;
        status_nxt[`FSBC_ST_ERASE_ERR] = erase_err_r;
        status_nxt[`FSBC_ST_PROG_ERR]  = prog_err_r;
        status_nxt[`FSBC_ST_RSVD]      = 1'b0;
        status_nxt[`FSBC_ST_PSUSP]     = state_r == ST_PSUSP;
        status_nxt[`FSBC_ST_LOCK_ERR]  = lock_err_r;
        // bit 0 only carries meaning while busy
        status_nxt[`FSBC_ST_BANK]      = busy && addr_bank != op_bank;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            status_r   <= `FSBC_ST_RESET;
            rd_allow_r <= 1'b0;
        end else begin
            status_r   <= status_nxt;
            // scanner owns the array during blank check
            rd_allow_r <= rd_req && state_r != ST_BLANK
                          && !(busy && rd_bank == op_bank);
        end
    end

    // axi4-lite slave; address and data taken in either order
    reg        awready_r;
    reg        wready_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;
    reg [7:0]  waddr_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;
    reg        arready_r;
    reg        rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0]  rresp_r;
    integer    i;

    wire aw_have = !awready_r;
    wire w_have  = !wready_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            bvalid_r   <= 1'b0;
            bresp_r    <= `FSBC_RESP_OKAY;
            waddr_r    <= 8'h00;
            wdata_r    <= 32'h0000_0000;
            wstrb_r    <= 4'h0;
            lock_cfg_r <= `FSBC_LOCK_RESET;
        end else begin
            if (awready_r && s_axi_awvalid) begin
                awready_r <= 1'b0;
                waddr_r   <= s_axi_awaddr;
            end
            if (wready_r && s_axi_wvalid) begin
                wready_r <= 1'b0;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (aw_have && w_have && !bvalid_r) begin
                bvalid_r <= 1'b1;
                bresp_r  <= `FSBC_RESP_OKAY;
                if (waddr_r[7:2] == `FSBC_REG_LOCK >> 2) begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (wstrb_r[i]) begin
                            lock_cfg_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
                        end
                    end
                end else if (waddr_r[7:2] != `FSBC_REG_STATUS >> 2
                             && waddr_r[7:2] != `FSBC_REG_INFO >> 2) begin
                    bresp_r <= `FSBC_RESP_DECERR;
                end
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `FSBC_RESP_OKAY;
        end else begin
            if (arready_r && s_axi_arvalid) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= `FSBC_RESP_OKAY;
                case (s_axi_araddr[7:2])
                    `FSBC_REG_STATUS >> 2: rdata_r <= {24'h000000, status_r};
                    `FSBC_REG_LOCK >> 2:   rdata_r <= lock_cfg_r;
                    `FSBC_REG_INFO >> 2:   rdata_r <= {13'h0000, state_r,
                                                       {(16-BANK_W){1'b0}}, op_bank};
                    default: begin
                        rdata_r <= 32'h0000_0000;
                        rresp_r <= `FSBC_RESP_DECERR;
                    end
                endcase
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign s_axi_awready      = awready_r;
    assign s_axi_wready       = wready_r;
    assign s_axi_bvalid       = bvalid_r;
    assign s_axi_bresp        = bresp_r;
    assign s_axi_arready      = arready_r;
    assign s_axi_rvalid       = rvalid_r;
    assign s_axi_rdata        = rdata_r;
    assign s_axi_rresp        = rresp_r;
    assign rd_allow           = rd_allow_r;
    assign op_start           = op_start_r;
    assign op_is_erase        = op_is_erase_r;
    assign op_hold            = op_hold_r;
    assign op_sector          = op_sector_r;
    assign device_status_word = status_r;
endmodule // fsbc_top

/* sim/fsbc_checker.sv */
// fsbc_checker: port assertions for fsbc_top.
// assumes the status word lags the sequencer state by one cycle.
`timescale 1ns/1ps
module fsbc_checker (
    input wire       aclk,
    input wire       aresetn,
    input wire [7:0] device_status_word,
    input wire       op_start,
    input wire       op_hold,
    input wire       op_is_erase,
    input wire       scan_rd,
    input wire       rd_allow,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready
);
    wire [7:0] st = device_status_word;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rsvd_zero: assert property (!st[3])
        else $error("reserved bit set");
    a_ready_bank: assert property (st[7] |-> !st[0])
        else $error("bank bit set while ready");
    a_start_busy: assert property (op_start |-> ##[1:3] !st[7])
        else $error("no busy after start");
    a_scan_busy: assert property (scan_rd |-> ##[0:2] !st[7])
        else $error("ready during scan");
    a_psusp_flag: assert property ($rose(op_hold) && !op_is_erase |-> ##[0:3] st[2] && st[7])
        else $error("suspend flag missing");
    a_lock_ready: assert property ($rose(st[1]) |-> st[7])
        else $error("lock error while busy");
    a_scan_noread: assert property (scan_rd |=> !rd_allow)
        else $error("array read during scan");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    cover property (scan_rd);
    cover property (op_start);
    cover property (st[2]);
    cover property ($rose(st[5]));
endmodule // fsbc_checker

bind fsbc_top fsbc_checker u_chk (.aclk, .aresetn, .device_status_word, .op_start, .op_hold,
    .op_is_erase, .scan_rd, .rd_allow, .s_axi_bvalid, .s_axi_bready);

/* sim/fsbc_host.sv */
// fsbc_host: host write cycles on the flash pins and the array behind the scan.
// assumes pins sampled on aclk; one address and data word per write.
`timescale 1ns/1ps
module fsbc_host (
    input  wire        aclk,
    input  wire [25:0] scan_addr,
    input  wire        scan_rd,
    input  wire        dirty,
    output reg         ce_n = 1'h1,
    output reg         oe_n = 1'h1,
    output reg         we_n = 1'h1,
    output reg         address_valid_n = 1'h1,
    output reg  [25:0] addr = 26'h0,
    output reg  [15:0] dq = 16'h0,
    output reg  [15:0] scan_data = 16'hffff
);
    // data only valid the cycle after a read; otherwise it keeps changing
    always @(posedge aclk)
        scan_data <= !scan_rd ? ~scan_data : (dirty && scan_addr[2:0] == 3'h3) ? 16'hfeff : 16'hffff;
    task wr(input [25:0] a, input [15:0] d);
        begin
            @(posedge aclk);
            {ce_n, address_valid_n, addr} <= {2'h0, a};
            @(posedge aclk);
            address_valid_n <= 1'h1;
            @(posedge aclk);
            {we_n, dq} <= {1'h0, d};
            @(posedge aclk);
            we_n <= 1'h1;
            @(posedge aclk);
            {ce_n, addr, dq} <= {1'h1, ~a, ~d};
        end
    endtask
endmodule // fsbc_host

/* sim/tb.sv */
// tb: self-checking bench for fsbc_top; axi4-lite master and op engine live here.
// assumes fsbc_host drives the flash pins and answers scan reads.
`timescale 1ns/1ps
module tb;
    reg         aclk, aresetn, awv, wv, brdy, arv, rrdy, op_done, dirty;
    reg  [7:0]  awa, ara;
    reg  [31:0] wd;
    wire        ce_n, oe_n, we_n, avalid_n, scan_rd, awr, wrr, bv, arr, rv, rd_allow;
    wire [25:0] fa, scan_addr;
    wire [15:0] dq, scan_data;
    wire [7:0]  st;
    wire [13:0] osec;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     error_cnt, n_tests, cyc, k, i;
    reg  [50:0] rows [0:4];
    fsbc_top #(.WORDS(8)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .address_valid_n(avalid_n),
        .flash_addr(fa), .flash_dq_in(dq), .rd_req(1'h1), .rd_addr(fa), .rd_allow(rd_allow),
        .scan_addr(scan_addr), .scan_rd(scan_rd), .scan_data(scan_data), .op_start(),
        .op_is_erase(), .op_hold(), .op_sector(osec), .op_done(op_done), .op_fail(dirty),
        .device_status_word(st));
    fsbc_host host (.aclk(aclk), .scan_addr(scan_addr), .scan_rd(scan_rd), .dirty(dirty),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .address_valid_n(avalid_n), .addr(fa), .dq(dq),
        .scan_data(scan_data));
    task chk(input [39:0] got, input [39:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            if (error_cnt == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task axw(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            {awa, wd, awv, wv, brdy} <= {a, d, 3'h7};
            do begin
                @(posedge aclk);
                if (awr) awv <= 1'h0;
                if (wrr) wv <= 1'h0;
            end while (!bv);
            brdy <= 1'h0;
            chk(bresp, 40'h0);
        end
    endtask
    task axr(input [7:0] a, input [31:0] d, input [1:0] r);
        begin
            @(posedge aclk);
            {ara, arv, rrdy} <= {a, 2'h3};
            do begin
                @(posedge aclk);
                if (arr) arv <= 1'h0;
            end while (!rv);
            rrdy <= 1'h0;
            chk({rresp, rdata}, {r, d});
        end
    endtask
    // command at sector + 555h, then let state and status catch up
    task fw(input [13:0] s, input [15:0] d);
        begin
            host.wr({s, 12'h555}, d);
            repeat (4) @(negedge aclk);
        end
    endtask
    task settle;
        begin
            for (k = 0; k < 100 && st[7] !== 1'h1; k = k + 1) @(negedge aclk);
        end
    endtask
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end
    initial begin
        {aresetn, awv, wv, brdy, arv, rrdy, op_done, dirty} = 8'h0;
        {awa, ara, wd} = 48'h0;
        {error_cnt, n_tests, cyc} = 96'h0;
        rows[0] = {14'h0001, 12'h555, 16'h0033, 1'h0, 8'h80};
        rows[1] = {14'h0001, 12'h555, 16'h0033, 1'h1, 8'ha0};
        rows[2] = {14'h0002, 12'h554, 16'h0033, 1'h1, 8'ha0};
        rows[3] = {14'h0002, 12'h555, 16'h0071, 1'h0, 8'h80};
        rows[4] = {14'h0002, 12'h555, 16'h0133, 1'h1, 8'h80};
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk(st, 8'h80);
        for (i = 0; i < 5; i = i + 1) begin
            dirty <= rows[i][8];
            host.wr(rows[i][50:25], rows[i][24:9]);
            repeat (4) @(negedge aclk);
            settle;
            chk(st, rows[i][7:0]);
        end
        fw(14'h0c01, 16'h0010);
        chk({st[7], st[0], rd_allow}, 3'h1);
        fw(14'h3001, 16'h0070);
        chk({st[7], st[0], rd_allow}, 3'h2);
        fw(14'h0c01, 16'h0051);
        chk(st, 8'h84);
        fw(14'h0c02, 16'h0033);
        chk(st, 8'h84);
        fw(14'h0c01, 16'h0052);
        chk({st[7], st[2]}, 2'h0);
        @(posedge aclk);
        op_done <= 1'h1;
        @(posedge aclk);
        op_done <= 1'h0;
        settle;
        chk(st, 8'h90);
        axw(8'h04, 32'h8000_0c01);
        axr(8'h04, 32'h8000_0c01, 2'h0);
        axr(8'h0c, 32'h0, 2'h3);
        fw(14'h0c01, 16'h0010);
        chk(st, 8'h92);
        axr(8'h00, 32'h92, 2'h0);
        fw(14'h0801, 16'h0020);
        fw(14'h0801, 16'h0061);
        chk({st, osec}, {8'hd0, 14'h0801});
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk(st, 8'h80);
        end_of_test;
    end
endmodule // tb
